// File: common/bmspc_regs.vh
// Purpose: offsets, field positions, reset values for the bridge config block
// Assumes: 32-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef BMSPC_REGS_VH
`define BMSPC_REGS_VH
`define BMSPC_OFF_ERR_NMI 8'h44
`define BMSPC_OFF_STRAP 8'h48
`define BMSPC_OFF_PREFETCH 8'h4c
`define BMSPC_OFF_IRQ_STAT 8'h50
`define BMSPC_OFF_IRQ_MASK 8'h54
`define BMSPC_OFF_PF_STAT 8'h58
`define BMSPC_ERR_NMI_RST 32'h0000_0000
`define BMSPC_PREFETCH_RST 14'h2c00
`define BMSPC_PF_MASK 32'h0000_3fff
`define BMSPC_NMI_EN_BIT 0
`define BMSPC_LEGACY_BIT 0
`define BMSPC_HP_FIRST_BIT 2
`define BMSPC_HP_SECOND_BIT 3
`define BMSPC_BDV_LSB 8
`define BMSPC_CMD_MR 2'h0
`define BMSPC_CMD_MRL 2'h1
`define BMSPC_CMD_MRM 2'h2
`define BMSPC_CMD_NONE 2'h3
`define BMSPC_IRQ_BITS 3
`define BMSPC_BDV_DEFAULT 4'h5
`endif

// File: logic/bmspc_config.v
// Purpose: error-to-NMI, boot strap capture and read prefetch policy
// Assumes: single clock clk_in at 250 MHz, synchronous active-high reset
// Notes: register port reads return data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "bmspc_regs.vh"

module bmspc_config (
  input wire clk_in,
  input wire rst_in,
  input wire clk_en_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire power_good_input,
  input wire hot_plug_strap_first,
  input wire hot_plug_strap_second,
  input wire legacy_route_strap_in,
  input wire [3:0] buffer_delay_strap_in,
  input wire perr_n_in,
  input wire serr_n_in,
  output reg nmi_out,
  input wire compat_access_in,
  output wire route_secondary_out,
  output wire hot_plug_enable_first_out,
  output wire hot_plug_enable_second_out,
  input wire pcix_mode_in,
  input wire read_start_in,
  input wire [1:0] read_cmd_in,
  input wire master_prefetch_enable_n,
  input wire line_xfer_start_in,
  input wire line_req_ready_in,
  output wire line_req_out,
  output wire line_req_unrequested_out,
  output wire irq_out
);

  // synchronisers for pins from outside the clock domain
  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  wire pg_s = sync2_q[0];
  wire hp1_s = sync2_q[1];
  wire hp2_s = sync2_q[2];
  wire leg_s = sync2_q[3];
  wire perr_s = sync2_q[4];
  wire serr_s = sync2_q[5];
  wire comp_s = sync2_q[6];
  always @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= 7'h7e;
      sync2_q <= 7'h7e;
    end else if (clk_en_in) begin
      sync1_q <= {compat_access_in, serr_n_in, perr_n_in,
                  legacy_route_strap_in, hot_plug_strap_second,
                  hot_plug_strap_first, power_good_input};
      sync2_q <= sync1_q;
    end
  end

  // buffer delay strap resynchronised like the other pins, so a strap
  // still settling near power-good never lands half-changed; power-good
  // itself lags by the same two stages, keeping the two aligned
  reg [3:0] bdv_sync1_q;
  reg [3:0] bdv_sync2_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      bdv_sync1_q <= `BMSPC_BDV_DEFAULT;
      bdv_sync2_q <= `BMSPC_BDV_DEFAULT;
    end else if (clk_en_in) begin
      bdv_sync1_q <= buffer_delay_strap_in;
      bdv_sync2_q <= bdv_sync1_q;
    end
  end

  // registers
  reg [31:0] err_nmi_q;
  reg [3:0] bdv_q;
  reg hp1_q;
  reg hp2_q;
  reg legacy_q;
  reg [13:0] pf_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg pg_d1_q;
  reg perr_d1_q;
  reg serr_d1_q;

  // edge detection on synchronised levels
  wire pg_rise = pg_s & ~pg_d1_q;
  wire perr_fall = ~perr_s & perr_d1_q;
  wire serr_fall = ~serr_s & serr_d1_q;
  wire err_event = perr_fall | serr_fall;

  // prefetch engine state
  localparam ST_IDLE = 2'd0;
  localparam ST_FIRST = 2'd1;
  localparam ST_BATCH = 2'd2;
  localparam ST_RUN = 2'd3;
  reg [1:0] state_q;
  reg [2:0] remain_q;
  reg cont_q;
  reg [7:0] req_cnt_q;
  reg [7:0] unreq_cnt_q;
  reg pending_q;

  // policy field selection by command
  reg [2:0] sel_count;
  reg sel_cont;
  always @* begin
    case (read_cmd_in)
      `BMSPC_CMD_MRM: begin
        sel_count = pf_q[12:10];
        sel_cont = pf_q[13];
      end
      `BMSPC_CMD_MRL: begin
        sel_count = pf_q[8:6];
        sel_cont = pf_q[9];
      end
      `BMSPC_CMD_MR: begin
        sel_count = pf_q[4:2];
        sel_cont = pf_q[5];
      end
      default: begin
        sel_count = 3'h0;
        sel_cont = 1'b0;
      end
    endcase
  end

  // a read qualifies only in conventional mode for an enabled master
  wire pf_start = read_start_in & ~pcix_mode_in & ~master_prefetch_enable_n
                  & (read_cmd_in != `BMSPC_CMD_NONE);

  // request handshake: first line is requested, the rest speculative
  assign line_req_out = (state_q == ST_FIRST) | (state_q == ST_BATCH)
                        | ((state_q == ST_RUN) & pending_q);
  assign line_req_unrequested_out = line_req_out & (state_q != ST_FIRST);
  wire req_take = line_req_out & line_req_ready_in;

  // prefetch request sequencing
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      remain_q <= 3'h0;
      cont_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (clk_en_in) begin
      case (state_q)
        ST_IDLE: begin
          pending_q <= 1'b0;
          if (pf_start) begin
            state_q <= ST_FIRST;
            remain_q <= sel_count;
            cont_q <= sel_cont;
          end
        end
        ST_FIRST: begin
          if (req_take) begin
            if (remain_q != 3'h0) begin
              state_q <= ST_BATCH;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_BATCH: begin
          if (req_take) begin
            remain_q <= remain_q - 3'h1;
            if (remain_q == 3'h1) begin
              state_q <= ST_RUN;
            end
          end
        end
        default: begin
          // one new request per line that starts moving
          if (pcix_mode_in | ~cont_q) begin
            pending_q <= 1'b0;
          end else if (line_xfer_start_in) begin
            pending_q <= 1'b1;
          end else if (req_take) begin
            pending_q <= 1'b0;
          end
          // a qualifying read restarts the sequence; any other read
          // drops back to idle so a stale policy is never applied
          if (read_start_in & ~pf_start) begin
            state_q <= ST_IDLE;
          end else if (pf_start) begin
            state_q <= ST_FIRST;
            remain_q <= sel_count;
            cont_q <= sel_cont;
          end
        end
      endcase
    end
  end

  // requested and unrequested issue counts
  always @(posedge clk_in) begin
    if (rst_in) begin
      req_cnt_q <= 8'h00;
      unreq_cnt_q <= 8'h00;
    end else if (clk_en_in && req_take) begin
      if (state_q == ST_FIRST) begin
        req_cnt_q <= req_cnt_q + 8'h01;
      end else begin
        unreq_cnt_q <= unreq_cnt_q + 8'h01;
      end
    end
  end

  // strap capture on power-good rising
  always @(posedge clk_in) begin
    if (rst_in) begin
      pg_d1_q <= 1'b0;
      bdv_q <= `BMSPC_BDV_DEFAULT;
      hp1_q <= 1'b0;
      hp2_q <= 1'b0;
    end else if (clk_en_in) begin
      pg_d1_q <= pg_s;
      if (pg_rise) begin
        bdv_q <= bdv_sync2_q;
        hp1_q <= hp1_s;
        hp2_q <= hp2_s;
      end
    end
  end

  // legacy routing bit: strap default, software writable
  always @(posedge clk_in) begin
    if (rst_in) begin
      legacy_q <= 1'b0;
    end else if (clk_en_in) begin
      if (pg_rise) begin
        legacy_q <= leg_s;
      end else if (wr_in && addr_in == `BMSPC_OFF_STRAP) begin
        legacy_q <= wdata_in[`BMSPC_LEGACY_BIT];
      end
    end
  end
  assign route_secondary_out = legacy_q & comp_s;
  assign hot_plug_enable_first_out = hp1_q;
  assign hot_plug_enable_second_out = hp2_q;

  // writable registers
  always @(posedge clk_in) begin
    if (rst_in) begin
      err_nmi_q <= `BMSPC_ERR_NMI_RST;
      pf_q <= `BMSPC_PREFETCH_RST;
      irq_mask_q <= 3'h0;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == `BMSPC_OFF_ERR_NMI) begin
        err_nmi_q <= wdata_in;
      end else if (addr_in == `BMSPC_OFF_PREFETCH) begin
        pf_q <= wdata_in[13:0];
      end else if (addr_in == `BMSPC_OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_in[2:0];
      end
    end
  end

  // NMI pulse on each error assertion while enabled
  always @(posedge clk_in) begin
    if (rst_in) begin
      perr_d1_q <= 1'b1;
      serr_d1_q <= 1'b1;
      nmi_out <= 1'b0;
    end else if (clk_en_in) begin
      perr_d1_q <= perr_s;
      serr_d1_q <= serr_s;
      nmi_out <= err_event & err_nmi_q[`BMSPC_NMI_EN_BIT];
    end
  end

  // sticky status: error, power-good capture, prefetch started
  // mask shares the status layout; the level output needs no own clear
  wire [2:0] irq_set = {pf_start, pg_rise, err_event};
  wire irq_clr_wr = wr_in && (addr_in == `BMSPC_OFF_IRQ_STAT);
  genvar gi;
  generate
    for (gi = 0; gi < `BMSPC_IRQ_BITS; gi = gi + 1) begin : g_irq
      always @(posedge clk_in) begin
        if (rst_in) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (clk_en_in) begin
          if (irq_set[gi]) begin
            irq_stat_q[gi] <= 1'b1; // set wins over clear
          end else if (irq_clr_wr && wdata_in[gi]) begin
            irq_stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // read data, one cycle after the strobe
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (!rd_in) begin
        rdata_out <= 32'h0000_0000;
      end else if (addr_in == `BMSPC_OFF_ERR_NMI) begin
        rdata_out <= err_nmi_q;
      end else if (addr_in == `BMSPC_OFF_STRAP) begin
        rdata_out <= {20'h0_0000, bdv_q, 4'h0, hp2_q, hp1_q, 1'b0,
                      legacy_q};
      end else if (addr_in == `BMSPC_OFF_PREFETCH) begin
        rdata_out <= {18'h0_0000, pf_q};
      end else if (addr_in == `BMSPC_OFF_IRQ_STAT) begin
        rdata_out <= {29'h0000_0000, irq_stat_q};
      end else if (addr_in == `BMSPC_OFF_IRQ_MASK) begin
        rdata_out <= {29'h0000_0000, irq_mask_q};
      end else if (addr_in == `BMSPC_OFF_PF_STAT) begin
        rdata_out <= {10'h000, state_q, remain_q, pending_q,
                      unreq_cnt_q, req_cnt_q};
      end else begin
        rdata_out <= 32'h0000_0000;
      end
    end
  end

endmodule // bmspc_config
`default_nettype wire

// File: bench/bmspc_props.sv
// Purpose: port checker for the bridge config block
// Assumes: clk_en_in held high
// Notes: counts cycles since an error line was last low
`timescale 1ns/1ps
`default_nettype none
module bmspc_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic perr_n_in,
  input wire logic serr_n_in,
  input wire logic nmi_out,
  input wire logic compat_access_in,
  input wire logic route_secondary_out,
  input wire logic pcix_mode_in,
  input wire logic read_start_in,
  input wire logic [1:0] read_cmd_in,
  input wire logic master_prefetch_enable_n,
  input wire logic line_req_ready_in,
  input wire logic line_req_out,
  input wire logic line_req_unrequested_out
);
  reg [2:0] age_q;
  // saturating age of the last low error level
  always @(posedge clk_in) begin
    if (rst_in || !perr_n_in || !serr_n_in) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(a); $past(rd_in) && $past(addr_in) == a; endsequence
  property p_idle; !$past(rd_in) |-> rdata_out == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_pf; s_rd(8'h4c) |-> rdata_out[31:14] == 18'h0_0000; endproperty
  a_pf: assert property (p_pf) else $error("prefetch upper bits set");
  property p_strap; s_rd(8'h48) |->
    {rdata_out[31:12], rdata_out[7:4], rdata_out[1]} == 25'h000_0000; endproperty
  a_strap: assert property (p_strap) else $error("strap spare bits set");
  property p_nmi; nmi_out |-> age_q < 3'h6; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without error");
  property p_pulse; nmi_out |=> !nmi_out; endproperty
  a_pulse: assert property (p_pulse) else $error("nmi too long");
  property p_route; route_secondary_out |->
    $past(compat_access_in, 2) || $past(compat_access_in, 3); endproperty
  a_route: assert property (p_route) else $error("route without compat");
  property p_hold; line_req_out && !line_req_ready_in && !read_start_in
    |=> line_req_out && $stable(line_req_unrequested_out); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_first; $rose(line_req_out) && $past(read_start_in) |->
    !line_req_unrequested_out && !$past(pcix_mode_in) && $past(read_cmd_in)
    != 2'h3 && !$past(master_prefetch_enable_n); endproperty
  a_first: assert property (p_first) else $error("bad first line");
  c_nmi: cover property (nmi_out);
  c_unreq: cover property (line_req_ready_in && line_req_unrequested_out);
  c_route: cover property (route_secondary_out);
endmodule // bmspc_props
bind bmspc_config bmspc_props i_props (.*);
`default_nettype wire

// File: bench/bmspc_link_model.sv
// Purpose: link side model granting cacheline requests
// Assumes: a request stands until granted
// Notes: slow_in grants only every other cycle
`timescale 1ns/1ps
`default_nettype none
module bmspc_link_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic req_in,
  output var logic ready_out = 1'b0
);
  logic tgl_q = 1'b0;
  // one grant per waiting line, stalling on odd cycles when slow
  always @(posedge clk_in) begin
    tgl_q <= ~tgl_q;
    ready_out <= req_in && (!slow_in || tgl_q);
  end
endmodule // bmspc_link_model
`default_nettype wire

// File: bench/tb_bmspc_config.sv
// Purpose: self-checking bench for the bridge config block
// Assumes: 4 ns clock, clk_en_in held high
// Notes: read data checked against a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module tb_bmspc_config;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic power_good_input = 1'b0, hot_plug_strap_first = 1'b0;
  logic hot_plug_strap_second = 1'b0, legacy_route_strap_in = 1'b0;
  logic perr_n_in = 1'b1, serr_n_in = 1'b1, compat_access_in = 1'b0;
  logic pcix_mode_in = 1'b0, read_start_in = 1'b0, line_xfer_start_in = 1'b0;
  logic master_prefetch_enable_n = 1'b0, slow = 1'b0, rd_was = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic [3:0] buffer_delay_strap_in = 4'h5;
  logic [1:0] read_cmd_in = 2'h3;
  wire [31:0] rdata_out;
  wire nmi_out, route_secondary_out, hot_plug_enable_first_out, irq_out;
  wire hot_plug_enable_second_out, line_req_ready_in, line_req_out;
  wire line_req_unrequested_out;
  int bad_count = 0, total_checks = 0, seed = 6, reqs = 0, unr = 0;
  int nmis = 0, n;
  logic [31:0] exp_q[$];
  always #2 clk_in = ~clk_in;
  bmspc_config i_dut (.clk_en_in(1'b1), .*);
  bmspc_link_model i_link (.clk_in(clk_in), .slow_in(slow),
    .req_in(line_req_out), .ready_out(line_req_ready_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // one register cycle; a read notes its expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask
  // start a master read, send x line starts, count granted lines
  task automatic pf(input logic [1:0] c, input int x, input int want);
    @(posedge clk_in);
    reqs = 0;
    unr = 0;
    read_cmd_in <= c;
    read_start_in <= 1'b1;
    @(posedge clk_in);
    read_start_in <= 1'b0;
    for (int p = 0; p <= x; p++) begin
      for (int i = 0; i < 99 && reqs < want - x + p; i++) @(posedge clk_in);
      line_xfer_start_in <= p < x;
      @(posedge clk_in);
      line_xfer_start_in <= 1'b0;
    end
    settle(10);
    check(reqs, want);
    if (reqs < want) finish_test();
  endtask
  // read results pop the oldest note; grants and NMI pulses counted
  always @(posedge clk_in) rd_was <= rd_in;
  always @(negedge clk_in) begin
    if (rd_was) check(rdata_out, exp_q.pop_front());
    if (line_req_out && line_req_ready_in) reqs++;
    if (line_req_out && line_req_ready_in) unr += line_req_unrequested_out;
    if (nmi_out) nmis++;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(0, 8'h44, 32'h0000_0000);
    bus(0, 8'h4c, 32'h0000_2c00);
    bus(0, 8'h7c, 32'h0000_0000);
    bus(1, 8'h4c, 32'hffff_ffff);
    bus(0, 8'h4c, 32'h0000_3fff);
    bus(1, 8'h48, 32'hffff_ffff);
    bus(0, 8'h48, 32'h0000_0501);
    bus(1, 8'h44, 32'hffff_fffe);
    bus(0, 8'h44, 32'hffff_fffe);
    // straps count only from power-good; single-slot kept inactive
    hot_plug_strap_first <= 1'b1;
    buffer_delay_strap_in <= 4'h5 + {1'b0, 3'($random(seed))};
    settle(4);
    check(hot_plug_enable_first_out, 1'b0);
    @(posedge clk_in);
    power_good_input <= 1'b1;
    settle(8);
    check(hot_plug_enable_first_out, 1'b1);
    check(hot_plug_enable_second_out, 1'b0);
    bus(0, 8'h48, {20'h0_0000, buffer_delay_strap_in, 8'h04});
    compat_access_in <= 1'b1;
    bus(1, 8'h48, 32'h0000_0001);
    settle(4);
    check(route_secondary_out, 1'b1);
    bus(1, 8'h48, 32'h0000_0000);
    settle(1);
    check(route_secondary_out, 1'b0);
    // error lines in turn, the last with the enable cleared
    bus(1, 8'h54, 32'h0000_0000);
    bus(1, 8'h50, 32'h0000_0007);
    for (int k = 0; k < 3; k++) begin
      bus(1, 8'h44, k == 2 ? 32'hffff_fffe : 32'h0000_0001);
      nmis = 0;
      perr_n_in <= k[0];
      serr_n_in <= !k[0];
      repeat (2) @(posedge clk_in);
      perr_n_in <= 1'b1;
      serr_n_in <= 1'b1;
      settle(12);
      check(nmis, k < 2);
    end
    check(irq_out, 1'b0);
    bus(1, 8'h54, 32'h0000_0001);
    settle(2);
    check(irq_out, 1'b1);
    bus(1, 8'h50, 32'h0000_0001);
    settle(2);
    check(irq_out, 1'b0);
    // each command with a random count and continuous on
    for (int c = 0; c < 3; c++) begin
      n = $random(seed) & 7;
      bus(1, 8'h4c, (n << (2 + 4 * c)) | (32 << (4 * c)));
      slow <= c[0];
      pf(c[1:0], 0, n + 1);
      check(unr, n);
      pf(c[1:0], 2, n + 3);
    end
    bus(1, 8'h4c, 32'h0000_1c00);
    pf(2'h2, 1, 8);
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_in);
      pcix_mode_in <= r == 0;
      master_prefetch_enable_n <= r == 1;
      pf(r == 2 ? 2'h3 : 2'h2, 0, 0);
    end
    finish_test();
  end
endmodule // tb_bmspc_config
`default_nettype wire
